// ### prf_defs.svh
// Overview of operation
// [R1] Keep one enable bit per upper node.
// [R2] Async filter first, then this filter.
// [R3] Clear node bit routes to async context.
// [R4] Compare node bits only for local bus.
// [R5] Remote packets unacknowledged unless bit 31 set.
// [R6] Bit 31 accepts all remote requests.
// [R7] Bit 31 survives host bus reset.
// [R8] Bit n enables node n plus 32.
// [R9] Set address sets, clear address clears.
// [R10] Readable, settable, clearable; resets to zero.
// [R11] First stage needs async filter bit set.
// [R12] Zero writes change nothing; both read contents.
`ifndef PRF_DEFS_SVH
`define PRF_DEFS_SVH
`define PRF_ADDR_W 12
`define PRF_OFS_ASYNC_LO_SET 12'h108
`define PRF_OFS_ASYNC_LO_CLR 12'h10C
`define PRF_OFS_ASYNC_HI_SET 12'h100
`define PRF_OFS_ASYNC_HI_CLR 12'h104
`define PRF_OFS_PHYS_HI_SET 12'h110
`define PRF_OFS_PHYS_HI_CLR 12'h114
`define PRF_OFS_PHYS_LO_SET 12'h118
`define PRF_OFS_PHYS_LO_CLR 12'h11C
`define PRF_RESET_VAL 32'h0000_0000
`define PRF_ALL_BUS_BIT 31
`define PRF_NODE_BASE 6'h20
`define PRF_LOCAL_BUS 10'h3FF
`endif

// ### prf_pkg.sv
`default_nettype none
package prf_pkg;
  typedef enum logic [1:0] {
    PRF_DEST_NONE = 2'b00,
    PRF_DEST_PHYS = 2'b01,
    PRF_DEST_ASYNC = 2'b10,
    PRF_DEST_DROP = 2'b11
  } prf_dest_e;
  typedef struct packed {
    logic valid;
    logic to_phys;
    logic [9:0] bus_id;
    logic [5:0] node_id;
  } prf_req_s;
  typedef struct packed {
    logic valid;
    prf_dest_e dest;
  } prf_result_s;
endpackage : prf_pkg
`default_nettype wire

// ### prf_filter.sv
// Implementation choice: the address-and-strobe port.
`include "prf_defs.svh"
`default_nettype none
module prf_filter (
  // Clock and reset
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic host_bus_reset_pin_in,
  // Register port
  input wire logic [`PRF_ADDR_W-1:0] reg_addr_in,
  input wire logic [31:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [31:0] reg_rdata_out,
  // Incoming request and decision
  input wire prf_pkg::prf_req_s req_in,
  output prf_pkg::prf_result_s result_out,
  output logic accept_remote_bus_requests_out
);
  import prf_pkg::*;

  logic [31:0] async_lo;
  logic [31:0] async_hi;
  logic [31:0] phys_lo;
  logic [30:0] per_node_physical_enable;
  logic accept_remote_bus_requests;
  logic rst_sync1;
  logic rst_sync2;
  logic [31:0] next_phys_hi;

  // Bit clear/set; zero bits leave a filter bit alone.
  function automatic logic [31:0] apply_sc(input logic [31:0] cur, input logic [`PRF_ADDR_W-1:0] a,
                                           input logic [`PRF_ADDR_W-1:0] set_a);
    logic [31:0] v;
    v = cur;
    if (a == set_a) begin
      v = cur | reg_wdata_in; // R9 R12
    end else if (a == set_a + `PRF_ADDR_W'(4)) begin
      v = cur & ~reg_wdata_in; // R9 R12
    end
    return v;
  endfunction : apply_sc

  function automatic logic is_pair(input logic [`PRF_ADDR_W-1:0] a,
                                   input logic [`PRF_ADDR_W-1:0] set_a);
    return (a == set_a) || (a == set_a + `PRF_ADDR_W'(4));
  endfunction : is_pair

  // Both halves of the high register see one set/clear result, so they cannot disagree.
  assign next_phys_hi = apply_sc({accept_remote_bus_requests, per_node_physical_enable},
                                 reg_addr_in, `PRF_OFS_PHYS_HI_SET); // R9 R12

  // The host reset pin comes from outside, so it is synchronised first.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rst_sync1 <= 1'b0;
      rst_sync2 <= 1'b0;
    end else begin
      rst_sync1 <= host_bus_reset_pin_in;
      rst_sync2 <= rst_sync1;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      async_lo <= `PRF_RESET_VAL; // R10
      async_hi <= `PRF_RESET_VAL;
      phys_lo <= `PRF_RESET_VAL;
      per_node_physical_enable <= 31'h0000_0000; // R10
    end else if (rst_sync2) begin
      async_lo <= `PRF_RESET_VAL;
      async_hi <= `PRF_RESET_VAL;
      phys_lo <= `PRF_RESET_VAL;
      per_node_physical_enable <= 31'h0000_0000; // R7
    end else if (reg_wr_in) begin
      async_lo <= apply_sc(async_lo, reg_addr_in, `PRF_OFS_ASYNC_LO_SET);
      async_hi <= apply_sc(async_hi, reg_addr_in, `PRF_OFS_ASYNC_HI_SET);
      phys_lo <= apply_sc(phys_lo, reg_addr_in, `PRF_OFS_PHYS_LO_SET);
      per_node_physical_enable <= next_phys_hi[30:0]; // R1 R8
    end
  end

  // The all-buses bit ignores the host bus reset; only the core reset or a write to its clear address clears it.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      accept_remote_bus_requests <= 1'b0; // R10
    end else if (reg_wr_in) begin
      accept_remote_bus_requests <= next_phys_hi[`PRF_ALL_BUS_BIT]; // R7 R9
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      accept_remote_bus_requests_out <= 1'b0;
    end else begin
      accept_remote_bus_requests_out <= accept_remote_bus_requests;
    end
  end

  // Read data stands only in the cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (!reg_rd_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (is_pair(reg_addr_in, `PRF_OFS_PHYS_HI_SET)) begin
      reg_rdata_out <= {accept_remote_bus_requests, per_node_physical_enable}; // R10 R12
    end else if (is_pair(reg_addr_in, `PRF_OFS_PHYS_LO_SET)) begin
      reg_rdata_out <= phys_lo;
    end else if (is_pair(reg_addr_in, `PRF_OFS_ASYNC_HI_SET)) begin
      reg_rdata_out <= async_hi;
    end else if (is_pair(reg_addr_in, `PRF_OFS_ASYNC_LO_SET)) begin
      reg_rdata_out <= async_lo;
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end

  // Two-stage decision; node 63 is broadcast and has no enable bit.
  prf_dest_e next_dest;
  logic local_bus;
  logic async_ok;
  logic phys_ok;
  always_comb begin
    local_bus = (req_in.bus_id == `PRF_LOCAL_BUS) || (req_in.bus_id == 10'h000);
    async_ok = 1'b0;
    phys_ok = 1'b0;
    if (req_in.node_id < `PRF_NODE_BASE) begin
      async_ok = async_lo[req_in.node_id[4:0]];
      phys_ok = phys_lo[req_in.node_id[4:0]];
    end else if (req_in.node_id != 6'h3F) begin
      async_ok = async_hi[req_in.node_id[4:0]];
      phys_ok = per_node_physical_enable[req_in.node_id[4:0]]; // R8
    end
    if (!local_bus) begin
      next_dest = accept_remote_bus_requests ? (req_in.to_phys ? PRF_DEST_PHYS : PRF_DEST_ASYNC)
                                             : PRF_DEST_DROP; // R4 R5 R6
    end else if (!async_ok) begin
      next_dest = PRF_DEST_DROP; // R2 R11
    end else if (!req_in.to_phys) begin
      next_dest = PRF_DEST_ASYNC;
    end else begin
      next_dest = phys_ok ? PRF_DEST_PHYS : PRF_DEST_ASYNC; // R1 R2 R3
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      result_out <= '0;
    end else begin
      result_out.valid <= req_in.valid;
      result_out.dest <= req_in.valid ? next_dest : PRF_DEST_NONE;
    end
  end
endmodule : prf_filter
`default_nettype wire

// ### prf_filter_sva.sv
`default_nettype none
module prf_filter_sva (
  // Watched ports
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic host_bus_reset_pin_in,
  input wire logic reg_rd_in,
  input wire logic reg_wr_in,
  input wire logic [31:0] reg_rdata_out,
  input wire prf_pkg::prf_req_s req_in,
  input wire prf_pkg::prf_result_s result_out,
  input wire logic accept_remote_bus_requests_out
);
  import prf_pkg::*;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  logic far;
  logic acc;
  prf_dest_e d;
  assign far = req_in.valid && req_in.bus_id != 10'h3FF && req_in.bus_id != 10'h0;
  assign acc = accept_remote_bus_requests_out;
  assign d = result_out.dest;
  sequence near_req;
    req_in.valid && !far;
  endsequence
  // The enable output lags bit 31 by one edge, so it is read beside the answer.
  a_far_drop: assert property (far |=> acc || d == PRF_DEST_DROP)
    else $error("remote not dropped");
  a_far_pass: assert property (far |=> !acc || d == ($past(req_in.to_phys) ?
    PRF_DEST_PHYS : PRF_DEST_ASYNC)) else $error("remote not passed");
  a_rdata_idle: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
    else $error("idle rdata");
  a_answer_valid: assert property (1 |=> result_out.valid == $past(req_in.valid))
    else $error("answer valid");
  a_top_drop: assert property (near_req and req_in.node_id == 6'h3F |=> d == PRF_DEST_DROP)
    else $error("node 63");
  a_near_async: assert property (near_req and !req_in.to_phys |=> d != PRF_DEST_PHYS)
    else $error("async to phys");
  a_bit31_keep: assert property ((host_bus_reset_pin_in && !reg_wr_in) [*3] |-> $stable(acc))
    else $error("bit 31 lost");
  a_reset_zero: assert property ($fell(rst_in) |-> !acc && !result_out.valid)
    else $error("reset value");
endmodule : prf_filter_sva
bind prf_filter prf_filter_sva i_sva (.*);
`default_nettype wire

// ### prf_node_model.sv
`default_nettype none
module prf_node_model (
  // Request toward the filter
  input wire logic core_clk_in,
  output var prf_pkg::prf_req_s req_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial req_out = '0;
  // Fields are inverted after a request so a stale node id never looks current.
  task automatic send(input logic [16:0] r);
    @(posedge core_clk_in);
    req_out <= {1'h1, r};
    @(posedge core_clk_in);
    req_out <= {1'h0, ~r};
  endtask : send
endmodule : prf_node_model
`default_nettype wire

// ### physical_request_filter_high_tb.sv
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("BAD %0t got %h", $time, a); end end
module physical_request_filter_high_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import prf_pkg::*;
  logic core_clk_in = 0, rst_in = 1, host_bus_reset_pin_in = 0;
  logic reg_wr_in = 0, reg_rd_in = 0, accept_remote_bus_requests_out;
  logic [11:0] reg_addr_in = '0;
  logic [31:0] reg_wdata_in = '0, reg_rdata_out;
  prf_req_s req_in;
  prf_result_s result_out;
  int n_fail = 0, n_checks = 0;
  logic [18:0] rows [8] = '{{1'h1, 10'h3FF, 6'h20, PRF_DEST_PHYS},
    {1'h1, 10'h0, 6'h21, PRF_DEST_ASYNC}, {1'h0, 10'h3FF, 6'h21, PRF_DEST_ASYNC},
    {1'h1, 10'h3FF, 6'h22, PRF_DEST_DROP}, {1'h1, 10'h3FF, 6'h3F, PRF_DEST_DROP},
    {1'h1, 10'h5, 6'h22, PRF_DEST_PHYS}, {1'h0, 10'h5, 6'h22, PRF_DEST_ASYNC},
    {1'h1, 10'h3FF, 6'h05, PRF_DEST_ASYNC}};
  prf_filter i_dut (.*);
  prf_node_model i_node (.core_clk_in, .req_out(req_in));
  initial forever #20 core_clk_in = ~core_clk_in;
  initial begin
    #50000;
    n_fail++;
    final_report();
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk_in);
    {reg_addr_in, reg_wdata_in, reg_wr_in} <= {a, d, 1'h1};
    @(posedge core_clk_in);
    reg_wr_in <= 1'h0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge core_clk_in);
    {reg_addr_in, reg_rd_in} <= {a, 1'h1};
    @(posedge core_clk_in);
    reg_rd_in <= 1'h0;
    #1 `CHK(reg_rdata_out, e)
  endtask : rd
  task automatic rq(input logic [18:0] r);
    i_node.send(r[18:2]);
    #1 `CHK(result_out, {1'h1, r[1:0]})
  endtask : rq
  task automatic final_report();
    if (n_fail == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : final_report
  initial begin
    repeat (12) @(posedge core_clk_in);
    rst_in <= 1'h0;
    rd(12'h110, 32'h0);
    wr(12'h100, 32'h3);
    wr(12'h108, 32'h20);
    wr(12'h110, 32'h8000_0001);
    rd(12'h114, 32'h8000_0001);
    foreach (rows[i]) rq(rows[i]);
    `CHK(accept_remote_bus_requests_out, 1'h1)
    wr(12'h118, 32'h20);
    rq({1'h1, 10'h3FF, 6'h05, PRF_DEST_PHYS});
    rd(12'h11C, 32'h20);
    rd(12'h10C, 32'h20);
    wr(12'h114, 32'h8000_0000);
    wr(12'h110, 32'h0);
    rd(12'h110, 32'h1);
    rq({1'h1, 10'h5, 6'h20, PRF_DEST_DROP});
    wr(12'h100, 32'h4000_0000);
    wr(12'h110, 32'hFFFF_FFFE);
    rq({1'h1, 10'h3FF, 6'h3E, PRF_DEST_PHYS});
    @(posedge core_clk_in) host_bus_reset_pin_in <= 1'h1;
    repeat (5) @(posedge core_clk_in);
    host_bus_reset_pin_in <= 1'h0;
    rd(12'h110, 32'h8000_0000);
    `CHK(accept_remote_bus_requests_out, 1'h1)
    rd(12'h104, 32'h0);
    rd(12'h200, 32'h0);
    final_report();
  end
endmodule : physical_request_filter_high_tb
`undef CHK
`default_nettype wire
